// ==== rtl/atsf_pkg.sv ====
// Constants and types for the converter trigger, sequencer and result queue
package atsf_pkg;
    localparam int CLK_MHZ = 100;
    localparam int GLITCH_NS = 10;
    localparam int GLITCH_RAW = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] GLITCH_CYC = 4'((GLITCH_RAW < 1) ? 1 : GLITCH_RAW);
    localparam int CONV_MHZ = 12;
    localparam int CONV_US = 15;
    localparam logic [7:0] CONV_TICKS = 8'(CONV_US * CONV_MHZ);
    localparam logic [7:0] DIV_RST = 8'(CLK_MHZ / CONV_MHZ);
    localparam logic [3:0] START_DIV = 4'h4;
    localparam int DEPTH = 4;
    localparam int RES_W = 12;
    localparam logic [7:0] OFF_RESULT = 8'h00;
    localparam logic [7:0] OFF_START = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_DELAY = 8'h0C;
    localparam logic [7:0] OFF_CLKSRC = 8'h10;
    localparam logic [7:0] OFF_GCFG = 8'h14;
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_FREE_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam int DLY_START_LSB = 0;
    localparam int DLY_CLK_LSB = 8;
    localparam logic [11:0] DLY_RST = 12'h000;
    localparam int CLKSRC_SEL_BIT = 0;
    localparam int CLKSRC_DIV_LSB = 8;
    localparam int GCFG_MUX_LSB = 0;
    localparam int GCFG_EXTIN_BIT = 3;
    localparam int GCFG_DIFF_BIT = 4;
    localparam int GCFG_PANEL_LSB = 5;
    localparam int GCFG_PREF_LSB = 8;
    localparam int GCFG_NREF_LSB = 10;
    localparam logic [11:0] GCFG_RST = 12'h000;
    localparam int RES_PEN_BIT = 12;
    localparam int RES_OVF_BIT = 13;
    localparam int RES_DONE_BIT = 14;
    localparam int RES_VALID_BIT = 15;
    localparam logic [2:0] PANEL_X = 3'h2;
    localparam logic [2:0] PANEL_Y = 3'h1;
    localparam logic [2:0] PANEL_Z = 3'h4;
    localparam logic [2:0] PANEL_PEN = 3'h5;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DELAY = 4'h2,
        ST_CONV = 4'h4,
        ST_PUSH = 4'h8
    } atsf_state_t;
endpackage

// ==== rtl/atsf_res_if.sv ====
// Result hand-off between the sequencer and the result queue
`timescale 1ns/1ns
interface atsf_res_if;
    logic req;
    logic ack;
    logic ovf;
    logic [11:0] data;
    modport src (output req, output data, input ack, input ovf);
    modport snk (input req, input data, output ack, output ovf);
endinterface

// ==== rtl/atsf_trigger.sv ====
// Trigger stage: pin filter, edge qualification, priming and lockout
`timescale 1ns/1ns
module atsf_trigger (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ext_trig,
    input wire logic i_edge_polarity,
    input wire logic i_ext_src,
    input wire logic i_free_run,
    input wire logic i_start_wr,
    input wire logic i_conv_done,
    output logic o_accept
);
    logic [1:0] sync;
    logic [3:0] stable_cnt;
    logic filt;
    logic filt_d;
    logic busy;
    logic armed;
    logic edge_hit;
    logic next_accept;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sync <= 2'h0;
        end else begin
            sync <= {sync[0], i_ext_trig};
        end
    end

    // A level must hold for the filter length before it is believed
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            stable_cnt <= 4'h0;
            filt <= 1'b0;
            filt_d <= 1'b0;
        end else begin
            filt_d <= filt;
            if (sync[1] == filt) begin
                stable_cnt <= 4'h0;
            end else if (stable_cnt == atsf_pkg::GLITCH_CYC - 4'h1) begin
                filt <= sync[1];
                stable_cnt <= 4'h0;
            end else begin
                stable_cnt <= stable_cnt + 4'h1;
            end
        end
    end

    assign edge_hit = i_edge_polarity ? (filt & ~filt_d)
                                      : (~filt & filt_d);
    assign next_accept = ~busy & (i_ext_src
        ? (edge_hit & (i_free_run | armed))
        : i_start_wr);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_accept <= 1'b0;
            busy <= 1'b0;
            armed <= 1'b0;
        end else begin
            o_accept <= next_accept;
            if (next_accept) begin
                busy <= 1'b1;
            end else if (i_conv_done) begin
                busy <= 1'b0;
            end
            // A write arms the stage; the arm is spent by the edge it takes
            if (i_start_wr && i_ext_src && !i_free_run) begin
                armed <= 1'b1;
            end else if (next_accept) begin
                armed <= 1'b0;
            end
        end
    end
endmodule

// ==== rtl/atsf_fifo.sv ====
// Four-entry result queue on the system clock
`timescale 1ns/1ns
module atsf_fifo (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_pop,
    input wire logic i_hold,
    atsf_res_if.snk res,
    output logic o_nempty,
    output logic [11:0] o_head
);
    logic [11:0] mem [0:atsf_pkg::DEPTH-1];
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic full;
    logic push;
    logic do_push;
    logic do_pop;

    assign full = (cnt == 3'(atsf_pkg::DEPTH));
    // A held system clock keeps the result out of the queue
    assign push = res.req & ~i_hold;
    assign res.ack = push;
    assign res.ovf = push & full;
    assign do_push = push & ~full;
    assign do_pop = i_pop & (cnt != 3'h0);
    assign o_nempty = (cnt != 3'h0);
    assign o_head = mem[rp];

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wp] <= res.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wp <= 2'h0;
            rp <= 2'h0;
            cnt <= 3'h0;
        end else begin
            if (do_push) begin
                wp <= wp + 2'h1;
            end
            if (do_pop) begin
                rp <= rp + 2'h1;
            end
            cnt <= cnt + {2'h0, do_push} - {2'h0, do_pop};
        end
    end
endmodule

// ==== rtl/atsf_top.sv ====
// Converter control: registers, clocking, start delay, sequencer, outputs
//
// Notes on behaviour
// - Start on qualified pin edge (pin source) or any write to the start register (software source).
// - Polarity bit picks rising or falling pin edges.
// - Pin glitches filtered; pulses of 10 ns or more are accepted.
// - After a trigger, further triggers are ignored until done.
// - Free-run with pin source: every edge starts unless busy.
// - Primed mode: start write arms one edge; re-arm after each.
// - Start delay counts programmed ticks, then starts the sequencer.
// - Sequencer converts, pushes result into queue, then signals done.
// - Queue holds four results; result register read pops oldest.
// - Result arriving into full queue is dropped; overflow bit set.
// - Done is shown as a flag in the result register.
// - Interrupt high while queue holds data; drops one cycle per read.
// - Wake follows same rule and asserts before the interrupt.
// - In pen-contact mode wake also ORs the pen detector.
// - Clock select: divided system clock near 12 MHz or aux clock two.
// - Clock delay field adds that many delay units to the clock.
// - Converter clock runs converter, sequencer, start divider; trigger on system clock.
// - Queue runs on system clock; held clock keeps results out.
// - One conversion takes about 15 microseconds.
// - Input select drives the mux; external select picks mux or pin.
// - Eight single-ended or four differential; pos and neg mux outputs.
// - Panel codes: 010 X plate, 001 Y plate, 100 contact, 101 pen.
`timescale 1ns/1ns
module atsf_top (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    input wire logic i_ext_trig,
    input wire logic i_aux_clk2,
    input wire logic i_pen_contact,
    input wire logic i_sysclk_hold,
    input wire logic [11:0] i_conv_data,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_conv_tick,
    output logic o_conv_start,
    output logic o_done,
    output logic [2:0] o_mux_out_pos,
    output logic [2:0] o_mux_out_neg,
    output logic o_ext_in_sel,
    output logic o_diff_mode,
    output logic [3:0] o_panel_drive,
    output logic [1:0] o_pos_ref_sel,
    output logic [1:0] o_neg_ref_sel,
    output logic o_conv_irq_line,
    output logic o_conv_wake_line
);
    // Software-visible configuration
    logic ext_src;
    logic edge_polarity;
    logic free_run;
    logic [7:0] start_delay_count;
    logic [3:0] clock_delay_field;
    logic clock_source_select;
    logic [7:0] clk_div;
    logic [2:0] input_select_field;
    logic external_input_select;
    logic diff_mode;
    logic [2:0] panel_driver_field;
    logic [1:0] pos_reference_select;
    logic [1:0] neg_reference_select;

    // Bus pipeline
    logic ap_valid;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic pop_req;
    logic start_wr;

    // Status
    logic done_flag;
    logic ovf_flag;
    logic read_drop;
    logic fifo_nempty;
    logic [11:0] fifo_head;
    logic [1:0] pen_sync;
    logic pen_mode;
    logic wake_fifo;

    // Clocking
    logic [7:0] div_cnt;
    logic src_tick;
    logic [2:0] aux_sync;
    logic [14:0] dly_sr;
    logic conv_tick;
    logic [3:0] sdiv_cnt;
    logic delay_tick;

    // Sequencer
    atsf_pkg::atsf_state_t state;
    logic [7:0] dcnt;
    logic [7:0] ccnt;
    logic accept;
    logic conv_done;
    logic [11:0] res_data;

    atsf_res_if res ();

    function automatic logic [31:0] read_value(input logic [7:0] addr,
        input logic [15:0] result_word, input logic [11:0] ctrl_word,
        input logic [11:0] dly_word, input logic [15:0] clk_word,
        input logic [11:0] gcfg_word);
        logic [31:0] value;
        value = 32'h0000_0000;
        if (addr == atsf_pkg::OFF_RESULT) begin
            value = {16'h0000, result_word};
        end else if (addr == atsf_pkg::OFF_CTRL) begin
            value = {20'h00000, ctrl_word};
        end else if (addr == atsf_pkg::OFF_DELAY) begin
            value = {20'h00000, dly_word};
        end else if (addr == atsf_pkg::OFF_CLKSRC) begin
            value = {16'h0000, clk_word};
        end else if (addr == atsf_pkg::OFF_GCFG) begin
            value = {20'h00000, gcfg_word};
        end
        return value;
    endfunction

    // Four plate drivers: {x+ to VCC, x- to GND, y+ to VCC, y- to GND}
    function automatic logic [3:0] panel_decode(input logic [2:0] code);
        logic [3:0] drv;
        drv = 4'h0;
        if (code == atsf_pkg::PANEL_X) begin
            drv = 4'hC;
        end else if (code == atsf_pkg::PANEL_Y) begin
            drv = 4'h3;
        end else if (code == atsf_pkg::PANEL_Z) begin
            drv = 4'h6;
        end
        return drv;
    endfunction

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign ap_valid = i_hsel & i_htrans[1] & i_hready;
    assign pop_req = ap_valid & ~i_hwrite
        & (i_haddr[7:0] == atsf_pkg::OFF_RESULT);
    assign start_wr = dp_wr & (dp_addr == atsf_pkg::OFF_START);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
            o_hrdata <= 32'h0000_0000;
        end else begin
            dp_wr <= ap_valid & i_hwrite;
            dp_addr <= i_haddr[7:0];
            if (ap_valid && !i_hwrite) begin
                o_hrdata <= read_value(i_haddr[7:0],
                    {fifo_nempty, done_flag, ovf_flag,
                     pen_sync[1] & pen_mode, fifo_head},
                    {9'h000, free_run, edge_polarity, ext_src},
                    {clock_delay_field, start_delay_count},
                    {clk_div, 7'h00, clock_source_select},
                    {neg_reference_select, pos_reference_select,
                     panel_driver_field, diff_mode,
                     external_input_select, input_select_field});
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            {free_run, edge_polarity, ext_src} <= atsf_pkg::CTRL_RST;
            {clock_delay_field, start_delay_count} <= atsf_pkg::DLY_RST;
            clock_source_select <= 1'b0;
            clk_div <= atsf_pkg::DIV_RST;
            {neg_reference_select, pos_reference_select, panel_driver_field,
             diff_mode, external_input_select, input_select_field}
                <= atsf_pkg::GCFG_RST;
        end else if (dp_wr) begin
            if (dp_addr == atsf_pkg::OFF_CTRL) begin
                ext_src <= i_hwdata[atsf_pkg::CTRL_EXT_BIT];
                edge_polarity <= i_hwdata[atsf_pkg::CTRL_POL_BIT];
                free_run <= i_hwdata[atsf_pkg::CTRL_FREE_BIT];
            end else if (dp_addr == atsf_pkg::OFF_DELAY) begin
                start_delay_count <= i_hwdata[atsf_pkg::DLY_START_LSB +: 8];
                clock_delay_field <= i_hwdata[atsf_pkg::DLY_CLK_LSB +: 4];
            end else if (dp_addr == atsf_pkg::OFF_CLKSRC) begin
                clock_source_select <= i_hwdata[atsf_pkg::CLKSRC_SEL_BIT];
                clk_div <= i_hwdata[atsf_pkg::CLKSRC_DIV_LSB +: 8];
            end else if (dp_addr == atsf_pkg::OFF_GCFG) begin
                input_select_field <= i_hwdata[atsf_pkg::GCFG_MUX_LSB +: 3];
                external_input_select <= i_hwdata[atsf_pkg::GCFG_EXTIN_BIT];
                diff_mode <= i_hwdata[atsf_pkg::GCFG_DIFF_BIT];
                panel_driver_field <= i_hwdata[atsf_pkg::GCFG_PANEL_LSB +: 3];
                pos_reference_select <= i_hwdata[atsf_pkg::GCFG_PREF_LSB +: 2];
                neg_reference_select <= i_hwdata[atsf_pkg::GCFG_NREF_LSB +: 2];
            end
        end
    end

    // Converter clock source: system clock divider or auxiliary clock two
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            div_cnt <= 8'h00;
            aux_sync <= 3'h0;
        end else begin
            aux_sync <= {aux_sync[1:0], i_aux_clk2};
            if ({1'b0, div_cnt} + 9'h001 >= {1'b0, clk_div}) begin
                div_cnt <= 8'h00;
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    assign src_tick = clock_source_select
        ? (aux_sync[1] & ~aux_sync[2])
        : ({1'b0, div_cnt} + 9'h001 >= {1'b0, clk_div});

    // Each delay unit is one system clock; the tap picks the total delay
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            dly_sr <= 15'h0000;
        end else begin
            dly_sr <= {dly_sr[13:0], src_tick};
        end
    end

    assign conv_tick = (clock_delay_field == 4'h0) ? src_tick
        : dly_sr[4'(clock_delay_field - 4'h1)];

    // The start delay runs on the converter clock divided down
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sdiv_cnt <= 4'h0;
        end else if (conv_tick) begin
            if (sdiv_cnt == atsf_pkg::START_DIV - 4'h1) begin
                sdiv_cnt <= 4'h0;
            end else begin
                sdiv_cnt <= sdiv_cnt + 4'h1;
            end
        end
    end

    assign delay_tick = conv_tick
        & (sdiv_cnt == atsf_pkg::START_DIV - 4'h1);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_conv_tick <= 1'b0;
        end else begin
            o_conv_tick <= conv_tick;
        end
    end

    atsf_trigger u_trigger (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ext_trig(i_ext_trig),
        .i_edge_polarity(edge_polarity),
        .i_ext_src(ext_src),
        .i_free_run(free_run),
        .i_start_wr(start_wr),
        .i_conv_done(conv_done),
        .o_accept(accept)
    );

    assign res.req = (state == atsf_pkg::ST_PUSH);
    assign res.data = res_data;
    assign conv_done = res.req & res.ack;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= atsf_pkg::ST_IDLE;
            dcnt <= 8'h00;
            ccnt <= 8'h00;
            res_data <= 12'h000;
            o_conv_start <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            o_done <= 1'b0;
            case (state)
                atsf_pkg::ST_IDLE: begin
                    dcnt <= 8'h00;
                    if (accept) begin
                        state <= atsf_pkg::ST_DELAY;
                    end
                end
                atsf_pkg::ST_DELAY: begin
                    if (dcnt == start_delay_count) begin
                        o_conv_start <= 1'b1;
                        ccnt <= 8'h00;
                        state <= atsf_pkg::ST_CONV;
                    end else if (delay_tick) begin
                        dcnt <= dcnt + 8'h01;
                    end
                end
                atsf_pkg::ST_CONV: begin
                    if (conv_tick) begin
                        // Conversion length is fixed in converter clocks
                        if (ccnt == atsf_pkg::CONV_TICKS - 8'h01) begin
                            res_data <= i_conv_data;
                            state <= atsf_pkg::ST_PUSH;
                        end else begin
                            ccnt <= ccnt + 8'h01;
                        end
                    end
                end
                atsf_pkg::ST_PUSH: begin
                    if (res.ack) begin
                        o_done <= 1'b1;
                        state <= atsf_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= atsf_pkg::ST_IDLE;
                end
            endcase
        end
    end

    atsf_fifo u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_pop(pop_req),
        .i_hold(i_sysclk_hold),
        .res(res),
        .o_nempty(fifo_nempty),
        .o_head(fifo_head)
    );

    // Sticky status: a set in the same cycle as the clearing read wins
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            done_flag <= 1'b0;
            ovf_flag <= 1'b0;
            read_drop <= 1'b0;
            pen_sync <= 2'h0;
            o_conv_irq_line <= 1'b0;
        end else begin
            pen_sync <= {pen_sync[0], i_pen_contact};
            read_drop <= pop_req;
            if (conv_done) begin
                done_flag <= 1'b1;
            end else if (pop_req) begin
                done_flag <= 1'b0;
            end
            if (res.ovf) begin
                ovf_flag <= 1'b1;
            end else if (pop_req) begin
                ovf_flag <= 1'b0;
            end
            // Registered, so it trails the queue term of the wake line by one cycle
            o_conv_irq_line <= wake_fifo;
        end
    end

    assign pen_mode = (panel_driver_field == atsf_pkg::PANEL_PEN);
    assign wake_fifo = fifo_nempty & ~read_drop;
    assign o_conv_wake_line = wake_fifo
        | (pen_mode & pen_sync[1]);

    // Differential pairs sit on adjacent inputs: even positive, odd negative
    assign o_mux_out_pos = diff_mode
        ? {input_select_field[1:0], 1'b0} : input_select_field;
    assign o_mux_out_neg = diff_mode
        ? {input_select_field[1:0], 1'b1} : 3'h0;
    assign o_ext_in_sel = external_input_select;
    assign o_diff_mode = diff_mode;
    assign o_panel_drive = panel_decode(panel_driver_field);
    assign o_pos_ref_sel = pos_reference_select;
    assign o_neg_ref_sel = neg_reference_select;
endmodule

// ==== tb/atsf_assertions.sv ====
// Port checker for the converter control block
`timescale 1ns/1ns
module atsf_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic i_pen_contact,
    input wire logic o_conv_start,
    input wire logic o_done,
    input wire logic [2:0] o_mux_out_neg,
    input wire logic o_diff_mode,
    input wire logic o_conv_irq_line,
    input wire logic o_conv_wake_line
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic rd;
    logic busy;
    // A pin held in pen mode lifts wake alone, so those cycles skip the lag
    assign rd = i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
        i_haddr[7:0] == 8'h00;
    always_ff @(posedge i_clk) begin
        if (i_srst || o_done) begin
            busy <= 1'b0;
        end else if (o_conv_start) begin
            busy <= 1'b1;
        end
    end
    AST_ONE_CONV: assert property (o_conv_start |-> !busy)
        else $error("start while busy");
    AST_DONE_CAUSE: assert property (o_done |-> busy)
        else $error("done without start");
    AST_CONV_LEN: assert property (o_conv_start |=> !o_done[*8])
        else $error("conversion too short");
    AST_WAKE_DROP: assert property (rd |=> !o_conv_wake_line)
        else $error("wake not dropped");
    AST_IRQ_DROP: assert property (rd |-> ##2 !o_conv_irq_line)
        else $error("irq not dropped");
    AST_IRQ_LAG: assert property (
        !$past(i_pen_contact, 3)
        |-> o_conv_irq_line == $past(o_conv_wake_line))
        else $error("irq not one cycle after wake");
    AST_WAKE_FIRST: assert property (
        $rose(o_conv_irq_line) |-> $past(o_conv_wake_line))
        else $error("irq rose before wake");
    AST_SE_NEG: assert property (
        !o_diff_mode |-> o_mux_out_neg == 3'h0)
        else $error("negative mux used single-ended");
endmodule
bind atsf_top atsf_checker chk_u (
    .i_clk(i_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .i_pen_contact(i_pen_contact),
    .o_conv_start(o_conv_start), .o_done(o_done),
    .o_mux_out_neg(o_mux_out_neg), .o_diff_mode(o_diff_mode),
    .o_conv_irq_line(o_conv_irq_line), .o_conv_wake_line(o_conv_wake_line)
);

// ==== tb/atsf_adc_model.sv ====
// Converter front end model: a new sample after each start
`timescale 1ns/1ns
module atsf_adc_model (
    input wire logic i_clk,
    input wire logic i_conv_start,
    output logic [11:0] o_data
);
    // Steady through a conversion, so the capture tick cannot matter
    initial o_data = 12'h100;
    always @(posedge i_clk) begin
        if (i_conv_start) begin
            o_data <= o_data + 12'h111;
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Bench: bus traffic, triggering, result queue and panel drive
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hw = 1'b0, trig = 1'b0;
    logic hready, start, done, irq, wake, pen = 1'b0, hold = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [3:0] panel, pd [3] = '{4'hC, 4'h3, 4'h6};
    logic [2:0] pc [3] = '{3'h2, 3'h1, 3'h4};
    logic [11:0] cdata;
    wire [11:0] cfg;
    logic [2:0] t = 3'h0;
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    int err_total = 0, comparisons = 0, n_start = 0, k = 0, c, c0, n0;
    initial forever #5 clk = ~clk;
    always @(posedge clk) n_start <= n_start + int'(start);
    always @(posedge clk) t <= t + 3'h1;
    atsf_top dut_u (
        .i_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hw), .i_hsize(3'h2), .i_hready(hready),
        .i_hwdata(hwdata), .i_ext_trig(trig), .i_aux_clk2(t[2]),
        .i_pen_contact(pen), .i_sysclk_hold(hold), .i_conv_data(cdata),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .o_conv_tick(),
        .o_conv_start(start), .o_done(done), .o_mux_out_pos(cfg[11:9]),
        .o_mux_out_neg(cfg[8:6]), .o_ext_in_sel(cfg[5]), .o_diff_mode(cfg[4]),
        .o_panel_drive(panel), .o_pos_ref_sel(cfg[3:2]),
        .o_neg_ref_sel(cfg[1:0]),
        .o_conv_irq_line(irq), .o_conv_wake_line(wake)
    );
    atsf_adc_model adc_u (.i_clk(clk), .i_conv_start(start), .o_data(cdata));
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        hw <= w;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rv = hrdata;
        @(negedge clk);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 3000 && done !== 1'b1; i++) begin
            @(negedge clk);
        end
        k++;
        chk("done", 32'h1, {31'h0, done});
    endtask
    // Counts cycles from the start write to the conversion start
    task automatic conv(logic [31:0] dly);
        bus(1'b1, 8'h0C, dly);
        bus(1'b1, 8'h04, 32'h0);
        for (c = 0; c < 500 && start !== 1'b1; c++) begin
            @(negedge clk);
        end
        wait_done();
    endtask
    task automatic rd_res(logic [3:0] f, int n);
        bus(1'b0, 8'h00, 32'h0);
        chk("result", {16'h0, f, 12'h100 + 12'(n) * 12'h111}, rv);
    endtask
    task automatic pin(logic v);
        @(posedge clk);
        trig <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic quiet(int n);
        repeat (30) @(negedge clk);
        chk("starts", n, n_start);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk("reset", ra[i] == 8'h10 ? 32'h800 : 32'h0, rv);
        end
        bus(1'b1, 8'h10, 32'h100);
        repeat (5) conv(32'h0);
        chk("irq wake", 32'h3, {30'h0, irq, wake});
        rd_res(4'hE, 1);
        for (int i = 2; i < 5; i++) rd_res(4'h8, i);
        bus(1'b0, 8'h00, 32'h0);
        chk("empty", 32'h0, {rv[15], wake});
        conv(32'h0);
        c0 = c;
        rd_res(4'hC, 6);
        conv(32'h3);
        chk("delay", 32'h1, {31'h0, c - c0 > 8 && c - c0 < 16});
        rd_res(4'hC, 7);
        bus(1'b1, 8'h08, 32'h7);
        n0 = n_start;
        pin(1'b1);
        pin(1'b0);
        pin(1'b1);
        pin(1'b0);
        wait_done();
        quiet(n0 + 1);
        rd_res(4'hC, k);
        bus(1'b1, 8'h08, 32'h5);
        pin(1'b1);
        quiet(n0 + 1);
        pin(1'b0);
        wait_done();
        rd_res(4'hC, k);
        bus(1'b1, 8'h08, 32'h3);
        pin(1'b1);
        pin(1'b0);
        quiet(n0 + 2);
        bus(1'b1, 8'h04, 32'h0);
        pin(1'b1);
        pin(1'b0);
        wait_done();
        pin(1'b1);
        pin(1'b0);
        quiet(n0 + 3);
        rd_res(4'hC, k);
        foreach (pc[i]) begin
            bus(1'b1, 8'h14, {24'h0, pc[i], 5'h0});
            chk("panel", {28'h0, pd[i]}, {28'h0, panel});
        end
        @(posedge clk) pen <= 1'b1;
        repeat (4) @(negedge clk);
        chk("pen off", 32'h0, {31'h0, wake});
        bus(1'b1, 8'h14, 32'hA0);
        chk("pen on", 32'h1, {31'h0, wake});
        @(posedge clk) pen <= 1'b0;
        bus(1'b1, 8'h14, 32'h61D);
        chk("cfg diff", 32'h4F9, {20'h0, cfg});
        bus(1'b1, 8'h14, 32'h5);
        chk("cfg single", 32'hA00, {20'h0, cfg});
        bus(1'b1, 8'h08, 32'h0);
        @(posedge clk) hold <= 1'b1;
        bus(1'b1, 8'h04, 32'h0);
        repeat (300) @(negedge clk);
        chk("held", 32'h0, {31'h0, wake});
        @(posedge clk) hold <= 1'b0;
        wait_done();
        rd_res(4'hC, k);
        bus(1'b1, 8'h10, 32'h1);
        conv(32'h3);
        chk("aux", 32'h1, {31'h0, c > 40});
        rd_res(4'hC, k);
        test_done();
    end
    initial begin
        #300000;
        err_total++;
        $display("CHECK FAILED watchdog exp finish got hang");
        test_done();
    end
endmodule
